// ==== design/sbma_pkg.sv ====
// package for the system bus master arbiter
// assumes a single 125 MHz reference clock and synchronous reset
package sbma_pkg;
    // command delay, printed figure in ns, converted to reference clocks
    localparam int CMD_DELAY_NS = 100;
    localparam int CLK_PERIOD_NS = 8;
    localparam int CMD_DELAY_CYC =
        (CMD_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CMD_DELAY_SHORT_CYC = 2;
    localparam int DLY_W = 8;
    localparam logic [DLY_W-1:0] DLY_LONG = DLY_W'(CMD_DELAY_CYC);
    localparam logic [DLY_W-1:0] DLY_SHORT = DLY_W'(CMD_DELAY_SHORT_CYC);
    localparam logic [1:0] SYNC_RESET = 2'h3;

    // one-hot command kinds, active high internally
    typedef struct packed {
        logic mem_rd;
        logic mem_wr;
        logic io_rd;
        logic io_wr;
    } sbma_cmd_t;

    // bus arbitration pins, all active low
    typedef struct packed {
        logic breq_n;
        logic bpro_n;
        logic busy_n;
    } sbma_arb_t;
endpackage

// ==== design/sbma_arbiter.sv ====
// system bus master arbiter: local request capture, bus arbitration,
// command timing and acknowledge return
// assumes bus pins pass through pad logic; bclk_n arrives as a pin
//
// How it works
// - arbitration steps on the falling edge of the shared bus clock
// - a local off-board request is captured each cycle while idle; strobe always enabled
// - after one bclk rise then fall, request the bus and block priority
// - request feeds parallel resolver; priority out feeds next master
// - priority input low with busy free grants the bus; assert busy and drive enable
// - busy held means the bus is ours alone until released
// - drive enable gates address and data drivers; off means no drive
// - after drive enable and a delay, drive exactly one matching command
// - address on bus while owned; data moves in step with the command
// - slave acknowledge reaches cpu ready; cpu waits until it arrives
`timescale 1ns/100ps
module sbma_arbiter #(
    parameter int ADDR_W = 16,
    parameter int DATA_W = 8
) (
    // clock, reset, enable
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // local cpu side
    input wire logic offboard_cmd_request_i,
    input wire logic cpu_mem_read_req_n_i,
    input wire logic cpu_mem_write_req_n_i,
    input wire logic cpu_io_read_req_n_i,
    input wire logic cpu_io_write_req_n_i,
    input wire logic command_delay_adjust_n_i,
    input wire logic [ADDR_W-1:0] cpu_addr_i,
    input wire logic [DATA_W-1:0] cpu_wdata_i,
    output logic [DATA_W-1:0] cpu_rdata_o,
    output logic cpu_ready_o,
    // bus arbitration pins
    input wire logic bclk_n_i,
    input wire logic bprn_n_i,
    input wire logic busy_n_i,
    output logic breq_n_o,
    output logic bpro_n_o,
    output logic busy_n_o,
    output logic busy_n_oe_o,
    output logic addr_data_drive_enable_n_o,
    // bus commands and acknowledges
    output logic mrdc_n_o,
    output logic mwtc_n_o,
    output logic iorc_n_o,
    output logic iowc_n_o,
    input wire logic xack_n_i,
    input wire logic aack_n_i,
    // bus address and data
    output logic [ADDR_W-1:0] bus_addr_o,
    output logic bus_addr_oe_o,
    input wire logic [DATA_W-1:0] bus_data_i,
    output logic [DATA_W-1:0] bus_data_o,
    output logic bus_data_oe_o
);
    typedef enum logic [2:0] {
        SBMA_IDLE, SBMA_WAIT_RISE, SBMA_WAIT_FALL, SBMA_REQ,
        SBMA_OWN, SBMA_CMD, SBMA_DONE
    } sbma_state_t;

    sbma_state_t state;
    logic [1:0] bclk_s;
    logic [1:0] bprn_s;
    logic [1:0] busy_s;
    logic [1:0] ack_s;
    logic [1:0] req_s;
    logic bclk_d;
    logic req_cap;
    localparam int DLY_W_L = sbma_pkg::DLY_W;
    logic [DLY_W_L-1:0] dly_cnt;
    sbma_pkg::sbma_cmd_t cmd_cap;
    sbma_pkg::sbma_cmd_t cmd_drv;
    logic rise;
    logic fall;
    logic ack;
    logic granted;

    function automatic sbma_pkg::sbma_cmd_t decode_cmd(
        input logic mr_n, input logic mw_n, input logic ir_n,
        input logic iw_n);
        sbma_pkg::sbma_cmd_t c;
        c = '0;
        // one command only, memory read first
        if (!mr_n) begin
            c.mem_rd = 1'b1;
        end else if (!mw_n) begin
            c.mem_wr = 1'b1;
        end else if (!ir_n) begin
            c.io_rd = 1'b1;
        end else if (!iw_n) begin
            c.io_wr = 1'b1;
        end
        return c;
    endfunction

    // pin synchronisers
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            bclk_s <= sbma_pkg::SYNC_RESET;
            bprn_s <= sbma_pkg::SYNC_RESET;
            busy_s <= sbma_pkg::SYNC_RESET;
            ack_s <= sbma_pkg::SYNC_RESET;
            req_s <= 2'h0;
            bclk_d <= 1'b1;
        end else if (ce_i) begin
            bclk_s <= {bclk_s[0], bclk_n_i};
            bprn_s <= {bprn_s[0], bprn_n_i};
            busy_s <= {busy_s[0], busy_n_i};
            ack_s <= {ack_s[0], xack_n_i & aack_n_i};
            req_s <= {req_s[0], offboard_cmd_request_i};
            bclk_d <= bclk_s[1];
        end
    end

    assign rise = bclk_s[1] & ~bclk_d;
    assign fall = ~bclk_s[1] & bclk_d;
    assign ack = ~ack_s[1];
    // grant only when priority is ours and no one else holds busy
    assign granted = ~bprn_s[1] & busy_s[1];

    // request capture, strobe always on
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            req_cap <= 1'b0;
            cmd_cap <= '0;
        end else if (ce_i) begin
            if (state == SBMA_IDLE) begin
                req_cap <= req_s[1];
                cmd_cap <= decode_cmd(cpu_mem_read_req_n_i,
                    cpu_mem_write_req_n_i, cpu_io_read_req_n_i,
                    cpu_io_write_req_n_i);
            end else if (state == SBMA_DONE) begin
                req_cap <= 1'b0;
                // kind for a follow-on command while the bus is held
                cmd_cap <= decode_cmd(cpu_mem_read_req_n_i,
                    cpu_mem_write_req_n_i, cpu_io_read_req_n_i,
                    cpu_io_write_req_n_i);
            end
        end
    end

    // arbitration sequencer
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state <= SBMA_IDLE;
        end else if (ce_i) begin
            unique case (state)
                SBMA_IDLE: begin
                    if (req_cap) begin
                        state <= SBMA_WAIT_RISE;
                    end
                end
                SBMA_WAIT_RISE: begin
                    if (rise) begin
                        state <= SBMA_WAIT_FALL;
                    end
                end
                SBMA_WAIT_FALL: begin
                    if (fall) begin
                        state <= SBMA_REQ;
                    end
                end
                SBMA_REQ: begin
                    if (fall && granted) begin
                        state <= SBMA_OWN;
                    end
                end
                SBMA_OWN: begin
                    if (dly_cnt == '0) begin
                        state <= SBMA_CMD;
                    end
                end
                SBMA_CMD: begin
                    if (ack) begin
                        state <= SBMA_DONE;
                    end
                end
                SBMA_DONE: begin
                    // slave drops ack when command withdrawn
                    if (!ack) begin
                        if (req_s[1]) begin
                            state <= SBMA_OWN;
                        end else begin
                            state <= SBMA_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // command delay counter
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            dly_cnt <= '0;
        end else if (ce_i) begin
            if (state != SBMA_OWN) begin
                dly_cnt <= command_delay_adjust_n_i ? sbma_pkg::DLY_LONG
                                                    : sbma_pkg::DLY_SHORT;
            end else if (dly_cnt != '0) begin
                dly_cnt <= dly_cnt - 1'b1;
            end
        end
    end

    // command outputs and read data capture
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cmd_drv <= '0;
            cpu_rdata_o <= '0;
        end else if (ce_i) begin
            if (state == SBMA_OWN && dly_cnt == '0) begin
                cmd_drv <= cmd_cap;
            end else if (state == SBMA_CMD && ack) begin
                cmd_drv <= '0;
                if (cmd_drv.mem_rd || cmd_drv.io_rd) begin
                    cpu_rdata_o <= bus_data_i;
                end
            end
        end
    end

    // address and write data latch
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            bus_addr_o <= '0;
            bus_data_o <= '0;
        end else if (ce_i && state == SBMA_OWN) begin
            bus_addr_o <= cpu_addr_i;
            bus_data_o <= cpu_wdata_i;
        end
    end

    logic own;
    assign own = (state == SBMA_OWN) || (state == SBMA_CMD) ||
                 (state == SBMA_DONE);
    assign breq_n_o = ~((state == SBMA_REQ) || own);
    assign bpro_n_o = (state == SBMA_IDLE) ? bprn_s[1] : 1'b1;
    assign busy_n_o = ~own;
    assign busy_n_oe_o = own;
    assign addr_data_drive_enable_n_o = ~own;
    assign bus_addr_oe_o = own;
    assign bus_data_oe_o = own & (cmd_drv.mem_wr | cmd_drv.io_wr);
    assign mrdc_n_o = ~cmd_drv.mem_rd;
    assign mwtc_n_o = ~cmd_drv.mem_wr;
    assign iorc_n_o = ~cmd_drv.io_rd;
    assign iowc_n_o = ~cmd_drv.io_wr;
    assign cpu_ready_o = (state == SBMA_CMD) & ack;

    // assertions
    property p_one_cmd;
        @(posedge ref_clk_i) disable iff (rst_i)
        $onehot0({mrdc_n_o, mwtc_n_o, iorc_n_o, iowc_n_o} ^ 4'hf);
    endproperty
    a_one_cmd: assert property (p_one_cmd) else $error("two commands");

    property p_cmd_needs_enable;
        @(posedge ref_clk_i) disable iff (rst_i)
        (!mrdc_n_o || !mwtc_n_o || !iorc_n_o || !iowc_n_o)
            |-> !addr_data_drive_enable_n_o && bus_addr_oe_o;
    endproperty
    a_cmd_needs_enable: assert property (p_cmd_needs_enable)
        else $error("command without drive enable");

    property p_busy_with_enable;
        @(posedge ref_clk_i) disable iff (rst_i)
        busy_n_o == addr_data_drive_enable_n_o;
    endproperty
    a_busy_with_enable: assert property (p_busy_with_enable)
        else $error("busy and enable differ");

    property p_breq_blocks_pro;
        @(posedge ref_clk_i) disable iff (rst_i)
        !breq_n_o |-> bpro_n_o;
    endproperty
    a_breq_blocks_pro: assert property (p_breq_blocks_pro)
        else $error("priority passed while requesting");

    property p_busy_has_breq;
        @(posedge ref_clk_i) disable iff (rst_i)
        !busy_n_o |-> !breq_n_o;
    endproperty
    a_busy_has_breq: assert property (p_busy_has_breq)
        else $error("busy without request");

    property p_ready_only_on_ack;
        @(posedge ref_clk_i) disable iff (rst_i)
        cpu_ready_o |-> ack;
    endproperty
    a_ready_only_on_ack: assert property (p_ready_only_on_ack)
        else $error("ready without acknowledge");

    property p_cmd_ends_after_ack;
        @(posedge ref_clk_i) disable iff (rst_i)
        (cpu_ready_o && ce_i) |=> (mrdc_n_o && mwtc_n_o && iorc_n_o &&
                                   iowc_n_o);
    endproperty
    a_cmd_ends_after_ack: assert property (p_cmd_ends_after_ack)
        else $error("command held after acknowledge");

    property p_grant_on_fall;
        @(posedge ref_clk_i) disable iff (rst_i)
        ($fell(busy_n_o) && $past(state) == SBMA_REQ) |-> $past(fall);
    endproperty
    a_grant_on_fall: assert property (p_grant_on_fall)
        else $error("grant taken off falling edge");

    property p_no_drive_idle;
        @(posedge ref_clk_i) disable iff (rst_i)
        addr_data_drive_enable_n_o |-> !bus_addr_oe_o && !bus_data_oe_o;
    endproperty
    a_no_drive_idle: assert property (p_no_drive_idle)
        else $error("drivers on while disabled");
endmodule // sbma_arbiter

// ==== test/sbma_bus_model.sv ====
// far side of the bus: free bus clock, resolver, other master, slave
// assumes one reference clock and the arbiter's active-low pins
`timescale 1ns/100ps
module sbma_bus_model #(
    parameter int DATA_W = 8,
    parameter logic [7:0] RD_VAL = 8'h5a
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // scenario controls
    input wire logic other_busy_i,
    input wire logic use_aack_i,
    // master pins
    input wire logic breq_n_i,
    input wire logic busy_n_i,
    input wire logic busy_n_oe_i,
    input wire sbma_pkg::sbma_cmd_t cmd_i,
    // bus side
    output logic bclk_n_o,
    output logic bprn_n_o,
    output logic busy_n_o,
    output logic xack_n_o,
    output logic aack_n_o,
    output logic [DATA_W-1:0] bus_data_o
);
    logic [1:0] div;
    logic [3:0] wait_cnt;
    logic ack;

    // bus clock runs free on the backplane
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            div <= 2'h0;
            bclk_n_o <= 1'b1;
        end else if (div == 2'h2) begin
            div <= 2'h0;
            bclk_n_o <= ~bclk_n_o;
        end else begin
            div <= div + 2'h1;
        end
    end

    // parallel resolver grants the requester
    assign bprn_n_o = breq_n_i;
    // wired busy line, another master may hold it
    assign busy_n_o = (busy_n_oe_i ? busy_n_i : 1'b1) & ~other_busy_i;

    // slave acknowledges after a wait, holds until command drops
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || cmd_i == 4'h0) begin
            wait_cnt <= 4'h0;
            ack <= 1'b0;
        end else if (wait_cnt == 4'h3) begin
            ack <= 1'b1;
        end else begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end
    assign xack_n_o = ~(ack & ~use_aack_i);
    assign aack_n_o = ~(ack & use_aack_i);
    // read data only while acknowledging a read, else a moving pattern
    assign bus_data_o = (ack && (cmd_i.mem_rd || cmd_i.io_rd)) ? RD_VAL
        : ~RD_VAL ^ {DATA_W{bclk_n_o}};
endmodule // sbma_bus_model

// ==== test/tb.sv ====
// self-checking bench for the system bus master arbiter
// assumes the arbiter and the bus model of this folder
`timescale 1ns/100ps
module tb;
    localparam int LIM = 400;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic req = 1'b0;
    logic ce = 1'b1;
    logic [3:0] kind_n = 4'hf;
    logic dly_n = 1'b1;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wdata = 8'h00;
    logic other_busy = 1'b0;
    logic use_aack = 1'b0;
    logic [7:0] rdata, bdata, bdata_in;
    logic ready, bclk_n, bprn_n, busy_in, breq_n, bpro_n, busy_n, busy_oe;
    logic en_n, mrdc_n, mwtc_n, iorc_n, iowc_n, xack_n, aack_n;
    logic addr_oe, data_oe;
    logic [15:0] baddr;
    logic [3:0] cmd_n;
    sbma_pkg::sbma_cmd_t cmd;
    int mismatches = 0;
    int n_tests = 0;

    always #4 clk = ~clk;
    assign cmd_n = {mrdc_n, mwtc_n, iorc_n, iowc_n};
    assign cmd = ~cmd_n;

    sbma_arbiter sbma_arbiter_i (.ref_clk_i(clk), .rst_i(rst), .ce_i(ce),
        .offboard_cmd_request_i(req), .cpu_mem_read_req_n_i(kind_n[3]),
        .cpu_mem_write_req_n_i(kind_n[2]), .cpu_io_read_req_n_i(kind_n[1]),
        .cpu_io_write_req_n_i(kind_n[0]), .command_delay_adjust_n_i(dly_n),
        .cpu_addr_i(addr), .cpu_wdata_i(wdata), .cpu_rdata_o(rdata),
        .cpu_ready_o(ready), .bclk_n_i(bclk_n), .bprn_n_i(bprn_n),
        .busy_n_i(busy_in), .breq_n_o(breq_n), .bpro_n_o(bpro_n),
        .busy_n_o(busy_n), .busy_n_oe_o(busy_oe),
        .addr_data_drive_enable_n_o(en_n), .mrdc_n_o(mrdc_n),
        .mwtc_n_o(mwtc_n), .iorc_n_o(iorc_n), .iowc_n_o(iowc_n),
        .xack_n_i(xack_n), .aack_n_i(aack_n), .bus_addr_o(baddr),
        .bus_addr_oe_o(addr_oe), .bus_data_i(bdata_in),
        .bus_data_o(bdata), .bus_data_oe_o(data_oe));

    sbma_bus_model sbma_bus_model_i (.ref_clk_i(clk), .rst_i(rst),
        .other_busy_i(other_busy), .use_aack_i(use_aack),
        .breq_n_i(breq_n), .busy_n_i(busy_n), .busy_n_oe_i(busy_oe),
        .cmd_i(cmd), .bclk_n_o(bclk_n), .bprn_n_o(bprn_n),
        .busy_n_o(busy_in), .xack_n_o(xack_n), .aack_n_o(aack_n),
        .bus_data_o(bdata_in));

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic ok, input string msg);
        n_tests++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("ERROR at %0t: %s", $time, msg);
        end
    endtask

    task automatic tmo(input int i);
        if (i >= LIM) begin
            chk(1'b0, "wait ran out");
            conclude();
        end
    endtask

    // one whole transfer of kind k (0 mem rd, 1 mem wr, 2 io rd, 3 io wr)
    task automatic xfer(input int k, input logic slow, input logic aa,
            input logic blk);
        int i;
        int n;
        logic [3:0] one;
        one = 4'h8 >> k;
        @(posedge clk);
        kind_n <= ~one;
        dly_n <= slow;
        use_aack <= aa;
        other_busy <= blk;
        addr <= 16'h4c30 + 16'(k);
        wdata <= 8'hc0 + 8'(k);
        req <= 1'b1;
        for (i = 0; i < LIM && breq_n !== 1'b0; i++) @(posedge clk);
        tmo(i);
        chk(bpro_n === 1'b1, "priority out not blocked");
        if (blk) begin
            for (i = 0; i < 60; i++) begin
                @(posedge clk);
                chk(busy_n === 1'b1 && en_n === 1'b1, "took busy bus");
            end
            other_busy <= 1'b0;
        end
        for (i = 0; i < LIM && busy_n !== 1'b0; i++) @(posedge clk);
        tmo(i);
        chk(en_n === 1'b0 && addr_oe === 1'b1 && busy_oe === 1'b1,
            "no drive on grant");
        for (n = 0; n < LIM && cmd_n === 4'hf; n++) @(posedge clk);
        tmo(n);
        chk(cmd_n === ~one, "wrong command");
        // command registers one edge after the count runs out
        chk(n == (slow ? sbma_pkg::CMD_DELAY_CYC
            : sbma_pkg::CMD_DELAY_SHORT_CYC) + 1, "command delay");
        chk(ready === 1'b0, "ready before ack");
        chk(baddr === addr && data_oe === (one[2] | one[0]),
            "addr/oe");
        if (k % 2 == 1) chk(bdata === wdata, "write data");
        for (i = 0; i < LIM && ready !== 1'b1; i++) @(posedge clk);
        tmo(i);
        req <= 1'b0;
        kind_n <= 4'hf;
        @(posedge clk);
        if (k % 2 == 0) chk(rdata === 8'h5a, "read data");
        for (i = 0; i < LIM && (busy_n !== 1'b1 || breq_n !== 1'b1); i++)
            @(posedge clk);
        tmo(i);
        chk(cmd_n === 4'hf && en_n === 1'b1 && addr_oe === 1'b0
            && data_oe === 1'b0 && busy_oe === 1'b0, "not released");
        // priority in reaches priority out through the synchroniser
        repeat (2) @(posedge clk);
        chk(bpro_n === 1'b1, "priority out not restored");
        $display("transfer %0d done", k);
    endtask

    task automatic t_idle();
        chk(breq_n === 1'b1 && busy_n === 1'b1 && en_n === 1'b1, "idle");
        chk(cmd_n === 4'hf && addr_oe === 1'b0 && ready === 1'b0, "idle");
        $display("idle test done");
    endtask

    task automatic t_freeze();
        int i;
        ce <= 1'b0;
        req <= 1'b1;
        kind_n <= 4'h7;
        for (i = 0; i < 30; i++) begin
            @(posedge clk);
            chk(breq_n === 1'b1 && busy_n === 1'b1, "ran frozen");
        end
        ce <= 1'b1;
        req <= 1'b0;
        kind_n <= 4'hf;
        for (i = 0; i < 30; i++) begin
            @(posedge clk);
            chk(breq_n === 1'b1, "stale request");
        end
        $display("freeze test done");
    endtask

    task automatic t_kinds_slow();
        for (int k = 0; k < 4; k++) xfer(k, 1'b1, 1'b0, 1'b0);
        $display("slow kinds test done");
    endtask

    task automatic t_kinds_fast_aack();
        for (int k = 0; k < 4; k++) xfer(k, 1'b0, 1'b1, 1'b0);
        $display("fast kinds test done");
    endtask

    task automatic t_blocked();
        xfer(1, 1'b0, 1'b0, 1'b1);
        $display("blocked bus test done");
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_idle();
        t_freeze();
        t_kinds_slow();
        t_kinds_fast_aack();
        t_blocked();
        conclude();
    end
endmodule // tb
